//--- src/cit_interval_timer.sv
// Calibrated interval timer core driven by a slow watchdog tick
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module cit_interval_timer import cit_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic wdt_tick_pin,
   input wire logic switch_input_pin,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic led_output_pin,
   output logic wdt_clear
);

   // ------------------------------------------------------------
   // Pin stage
   // ------------------------------------------------------------
   cit_pin_if pins ();

   // Both pins come from outside the clock domain
   cit_pin_sync u_pin_sync (
      .clk(clk),
      .srst(srst),
      .wdt_tick_pin(wdt_tick_pin),
      .switch_input_pin(switch_input_pin),
      .pins(pins.src)
   );

   // ------------------------------------------------------------
   // State and storage
   // ------------------------------------------------------------
   cit_state_e state_q;          // Sequencer state
   logic run_q;                  // Software run enable
   logic first_q;                // First calibration after init
   logic tick_en_q;              // Tick event unmasked
   logic sw_en_q;                // Switch event enabled
   logic cal_pending_q;          // Next tick starts a base period
   logic [6:0] step_cnt_q;       // Measurement step divider
   logic [15:0] meas_q;          // Measurement counter
   logic [7:0] base_q;           // Base-tick counter
   logic [7:0] interval_q;       // Interval counter in base periods
   logic [3:0] dbc_q;            // Debounce counter
   logic [2:0] key_q;            // Key-press counter
   logic led_q;                  // LED drive
   logic wdt_clear_q;            // Watchdog clear pulse
   logic [31:0] rdata_q;         // Read data, one cycle after strobe

   // ------------------------------------------------------------
   // Event decode
   // ------------------------------------------------------------
   logic tick_ev;                // Tick accepted while unmasked
   logic start_meas;             // Entering a measurement
   logic proc_tick;              // Debounce and counting this cycle
   logic step_en;                // One measurement step
   logic sw_ev;                  // Accepted switch edge
   logic dbc_done;               // Debounce expires this tick
   logic press_ok;               // Valid press sampled
   logic [2:0] key_sel;          // Key index after this tick
   logic [7:0] base_cur;         // Base count before decrement
   logic [7:0] base_nxt;         // Base count after decrement
   logic base_wrap;              // One base period complete
   logic [7:0] int_nxt;          // Interval after decrement
   logic int_expire;             // Interval complete

   // Tick taken in the idle state only when unmasked
   assign tick_ev = pins.tick_evt && tick_en_q && (state_q == ST_STOP);

   // Measurement starts after init or at each new base period [R1]
   assign start_meas = ((state_q == ST_INIT) && run_q) ||
                       (tick_ev && cal_pending_q);

   // Ordinary ticks, or the tick that ended a recalibration [R7]
   assign proc_tick = (tick_ev && !cal_pending_q) ||
                      ((state_q == ST_CALC) && !first_q);

   // Slow step rate for the measurement counter
   assign step_en = (state_q == ST_MEAS) && (step_cnt_q == STEP_CNT_MAX);

   // Switch edge honoured only while enabled [R9]
   assign sw_ev = pins.sw_fall && sw_en_q && (state_q != ST_INIT);

   // Debounce runs out on this tick [R11]
   assign dbc_done = proc_tick && (dbc_q == 4'h1);

   // Low level after the wait is a real press [R12]
   assign press_ok = dbc_done && !pins.sw_level;

   // Debounce result is folded in before the reload [R20]
   assign key_sel = press_ok ? next_key(key_q) : key_q;

   // Fresh calibration replaces the stored base count [R2]
   assign base_cur = (state_q == ST_CALC) ? calc_base(meas_q) : base_q;
   assign base_nxt = base_cur - 8'h01;

   // Base period ends when the counter lands on zero [R13]
   assign base_wrap = proc_tick && (base_nxt == 8'h00);
   assign int_nxt = interval_q - 8'h01;
   assign int_expire = base_wrap && (int_nxt == 8'h00);

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------

   // Clearing run holds the block in init; setting it restarts
   always_ff @(posedge clk) begin
      if (srst) begin
         run_q <= CTRL_RUN_RST;
      end else if (reg_wr && (reg_addr == CTRL_OFS)) begin
         run_q <= reg_wdata[CTRL_RUN_BIT];
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------

   // Idle in stop between ticks; each tick either counts or measures
   always_ff @(posedge clk) begin
      if (srst || !run_q) begin
         state_q <= ST_INIT;
      end else begin
         unique case (state_q)
            ST_INIT: begin
               state_q <= ST_MEAS;                    // [R2]
            end
            ST_MEAS: begin
               // Count until the next raw tick [R2]
               if (pins.tick_evt) begin
                  state_q <= ST_CALC;
               end
            end
            ST_CALC: begin
               state_q <= ST_STOP;                    // [R7]
            end
            ST_STOP: begin
               if (start_meas) begin
                  state_q <= ST_MEAS;                 // [R1]
               end
            end
         endcase
      end
   end

   // First pass after init loads, later passes also count
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         first_q <= 1'b1;
      end else if (state_q == ST_CALC) begin
         first_q <= 1'b0;
      end
   end

   // Tick masked during init, unmasked once it completes
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         tick_en_q <= 1'b0;                           // [R3]
      end else if ((state_q == ST_CALC) && first_q) begin
         tick_en_q <= 1'b1;                           // [R6]
      end
   end

   // Armed at each base wrap, consumed when measurement starts
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         cal_pending_q <= 1'b0;
      end else if (base_wrap) begin
         cal_pending_q <= 1'b1;                       // [R1]
      end else if (start_meas) begin
         cal_pending_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Period measurement
   // ------------------------------------------------------------

   // Divider only runs while measuring, so every run starts aligned
   always_ff @(posedge clk) begin
      if (srst || (state_q != ST_MEAS)) begin
         step_cnt_q <= 7'h00;
      end else if (step_en) begin
         step_cnt_q <= 7'h00;
      end else begin
         step_cnt_q <= step_cnt_q + 7'h01;
      end
   end

   // Preloaded so the wake-up delay is already counted [R8]
   // Saturates rather than wrapping if the tick goes missing
   always_ff @(posedge clk) begin
      if (srst) begin
         meas_q <= 16'h0000;
      end else if (start_meas) begin
         meas_q <= WAKE_LATENCY_OFFSET + SETUP_STEP;  // [R19] [R2]
      end else if (step_en && (meas_q != MEAS_MAX)) begin
         meas_q <= meas_q + 16'h0001;                 // [R2]
      end
   end

   // Watchdog cleared at measurement start and on every tick
   always_ff @(posedge clk) begin
      if (srst) begin
         wdt_clear_q <= 1'b0;
      end else begin
         wdt_clear_q <= start_meas ||                   // [R2]
                        tick_ev ||                      // [R10]
                        ((state_q == ST_MEAS) && pins.tick_evt);
      end
   end

   // ------------------------------------------------------------
   // Base and interval counting
   // ------------------------------------------------------------

   // Base counter loaded from the formula, stepped per tick
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         base_q <= 8'h00;
      end else if (proc_tick) begin
         base_q <= base_nxt;                          // [R13] [R16]
      end else if ((state_q == ST_CALC) && first_q) begin
         base_q <= calc_base(meas_q);                 // [R16] [R2]
      end
   end

   // Interval counts base periods; reload picks the current key
   always_ff @(posedge clk) begin
      if (srst) begin
         interval_q <= INTERVAL_TABLE[0];
      end else if ((state_q == ST_INIT) || ((state_q == ST_CALC) && first_q)) begin
         interval_q <= INTERVAL_TABLE[0];             // [R5]
      end else if (int_expire) begin
         interval_q <= INTERVAL_TABLE[key_sel];       // [R14] [R18]
      end else if (base_wrap) begin
         interval_q <= int_nxt;                       // [R13]
      end
   end

   // LED held off through init, toggled at each expiry
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         led_q <= 1'b0;
      end else if ((state_q == ST_CALC) && first_q) begin
         led_q <= 1'b0;                               // [R6]
      end else if (int_expire) begin
         led_q <= ~led_q;                             // [R14]
      end
   end

   // ------------------------------------------------------------
   // Debounce and key counting
   // ------------------------------------------------------------

   // Loaded by an edge, counted down by ticks only
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         dbc_q <= 4'h0;                               // [R4]
      end else if (sw_ev) begin
         dbc_q <= DEBOUNCE_LOAD;                      // [R9]
      end else if (proc_tick && (dbc_q != 4'h0)) begin
         dbc_q <= dbc_q - 4'h1;                       // [R10]
      end
   end

   // Switch disabled while bouncing, so chatter is ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         sw_en_q <= 1'b0;
      end else if (state_q == ST_INIT) begin
         sw_en_q <= 1'b1;                             // [R3]
      end else if (sw_ev) begin
         sw_en_q <= 1'b0;                             // [R9]
      end else if (dbc_done) begin
         sw_en_q <= 1'b1;                             // [R11]
      end
   end

   // Press count selects the next table entry
   always_ff @(posedge clk) begin
      if (srst || (state_q == ST_INIT)) begin
         key_q <= 3'h0;                               // [R4]
      end else if (press_ok) begin
         key_q <= key_sel;                            // [R12] [R17]
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------

   // Data valid in the cycle after the read strobe only
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            unique case (reg_addr)
               CTRL_OFS: begin
                  rdata_q[CTRL_RUN_BIT] <= run_q;
               end
               STATUS_OFS: begin
                  rdata_q[ST_LED_BIT] <= led_q;
                  rdata_q[ST_SWEN_BIT] <= sw_en_q;
                  rdata_q[ST_TICKEN_BIT] <= tick_en_q;
                  rdata_q[ST_CALP_BIT] <= cal_pending_q;
                  rdata_q[ST_STATE_LSB +: 2] <= state_q;
                  rdata_q[ST_DBC_LSB +: 4] <= dbc_q;
                  rdata_q[ST_KEY_LSB +: 3] <= key_q;
               end
               COUNT_OFS: begin
                  rdata_q[7:0] <= base_q;
                  rdata_q[CNT_INTERVAL_LSB +: 8] <= interval_q;
               end
               MEAS_OFS: begin
                  rdata_q[15:0] <= meas_q;
               end
               default: begin
                  // Unmapped addresses read as zero
                  rdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign led_output_pin = led_q;
   assign wdt_clear = wdt_clear_q;

endmodule : cit_interval_timer

//--- src/cit_pkg.sv
// Constants, types and helpers shared by the calibrated interval timer
//
// Functional notes
// (R1) Recalibrate tick period at each base start
// (R2) Clear, clear watchdog, count, convert, load
// (R3) Init: mask tick, falling switch edge enabled
// (R4) Init: clear debounce and key counters
// (R5) Interval starts at table entry zero
// (R6) After init: LED off, tick unmasked
// (R7) Idle between events; work only on events
// (R8) Preload measurement counter for wake latency
// (R9) Switch edge: debounce nine, disable switch
// (R10) Each tick: clear watchdog, step debounce; the tick that opens a recalibration only clears the watchdog
// (R11) Debounce end: re-enable switch, sample pin
// (R12) Low level counts a press, selects interval
// (R13) Base counter per tick; interval per base
// (R14) Interval expiry toggles LED and reloads
// (R15) Switch pulls low; LED output driven
// (R16) Base count is 66 minus count/128, adjusted
// (R17) Key counter wraps past table end
// (R18) Table holds one to five base periods
// (R19) Offset is forty steps plus one
// (R20) Debounce handled before base counting
package cit_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;   // System clock period
   localparam int STEP_NS = 700;        // One measurement count step
   // Least time, so round up to whole cycles
   localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] STEP_CNT_MAX = 7'(STEP_CYC - 1);

   // ------------------------------------------------------------
   // Calibration arithmetic
   // ------------------------------------------------------------
   localparam logic [15:0] WAKE_LATENCY_OFFSET = 16'h0028; // Forty steps
   localparam logic [15:0] SETUP_STEP = 16'h0001;          // Setup overhead
   localparam logic [15:0] MEAS_MAX = 16'hFFFF;            // Saturation
   localparam int MEAS_SHIFT = 7;                          // Divide by 128
   localparam logic [7:0] BASE_BIAS = 8'h42;               // 66
   localparam logic [7:0] BASE_LOW_LIMIT = 8'h1C;          // 28

   // ------------------------------------------------------------
   // Debounce and interval table
   // ------------------------------------------------------------
   localparam logic [3:0] DEBOUNCE_LOAD = 4'h9;
   localparam logic [2:0] KEY_LAST = 3'h4;                 // Last table index
   localparam logic [7:0] INTERVAL_TABLE [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05};

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] COUNT_OFS = 4'h8;
   localparam logic [3:0] MEAS_OFS = 4'hC;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam int ST_LED_BIT = 0;
   localparam int ST_SWEN_BIT = 1;
   localparam int ST_TICKEN_BIT = 2;
   localparam int ST_CALP_BIT = 3;
   localparam int ST_STATE_LSB = 4;
   localparam int ST_DBC_LSB = 8;
   localparam int ST_KEY_LSB = 16;
   localparam int CNT_INTERVAL_LSB = 8;

   // ------------------------------------------------------------
   // Sequencer states, Gray along init, measure, calc, idle
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_MEAS = 2'b01,
      ST_CALC = 2'b11,
      ST_STOP = 2'b10
   } cit_state_e;

   // Ticks per base period from a measured count
   function automatic logic [7:0] calc_base(input logic [15:0] cnt);
      logic [7:0] e;
      e = BASE_BIAS - 8'(cnt >> MEAS_SHIFT);
      if (e < BASE_LOW_LIMIT) begin
         e = e + 8'h01;
      end
      return e;
   endfunction : calc_base

   // Next key index, wrapping past the table end
   function automatic logic [2:0] next_key(input logic [2:0] k);
      return (k >= KEY_LAST) ? 3'h0 : 3'(k + 3'h1);
   endfunction : next_key

endpackage : cit_pkg

//--- src/cit_pin_if.sv
// Synchronised pin events passed from the pin stage to the timer core
`timescale 1ns/1ns
interface cit_pin_if;
   logic tick_evt;   // One-cycle pulse per watchdog tick
   logic sw_level;   // Synchronised switch level
   logic sw_fall;    // One-cycle pulse on switch falling edge
   modport src (output tick_evt, output sw_level, output sw_fall);
   modport dst (input tick_evt, input sw_level, input sw_fall);
endinterface : cit_pin_if

//--- src/cit_pin_sync.sv
// Two-stage synchronisers and edge detectors for the tick and switch pins
`timescale 1ns/1ns
module cit_pin_sync import cit_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic wdt_tick_pin,
   input wire logic switch_input_pin,
   cit_pin_if.src pins
);

   // ------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------
   logic tick_s1_q; // First stage, read only by second
   logic tick_s2_q; // Stable tick level
   logic tick_s3_q; // Delayed for edge detect
   logic sw_s1_q;   // First stage, read only by second
   logic sw_s2_q;   // Stable switch level
   logic sw_s3_q;   // Delayed for edge detect

   // Tick chain, idle low
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         tick_s1_q <= wdt_tick_pin;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   // Switch chain, idle high so reset gives no false press
   always_ff @(posedge clk) begin
      if (srst) begin
         sw_s1_q <= 1'b1;
         sw_s2_q <= 1'b1;
         sw_s3_q <= 1'b1;
      end else begin
         sw_s1_q <= switch_input_pin;
         sw_s2_q <= sw_s1_q;
         sw_s3_q <= sw_s2_q;
      end
   end

   // Events from the settled stages only
   assign pins.tick_evt = tick_s2_q & ~tick_s3_q;
   assign pins.sw_level = sw_s2_q;
   assign pins.sw_fall = sw_s3_q & ~sw_s2_q;   // Press pulls low [R15]

endmodule : cit_pin_sync

//--- tb/cit_props.sv
// Port-level assertions for the calibrated interval timer
`timescale 1ns/1ns
module cit_props import cit_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic wdt_tick_pin,
   input wire logic switch_input_pin,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic led_output_pin,
   input wire logic wdt_clear
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   logic [3:0] since_q; // Cycles since tick rise, write or reset
   logic armed_q; // Ticks are being answered
   logic tick_q; // Tick pin one cycle back
   // Saturating age counter, so late outputs show as large ages
   always_ff @(posedge clk) begin
      tick_q <= wdt_tick_pin;
      since_q <= (srst || reg_wr || (wdt_tick_pin && !tick_q)) ? 4'h0 :
         since_q + 4'(since_q != 4'hF);
   end
   // Armed by the first clear, disarmed by reset or a run-off write
   always_ff @(posedge clk) begin
      armed_q <= !srst && (armed_q || wdt_clear) &&
         !(reg_wr && reg_addr == CTRL_OFS && !reg_wdata[CTRL_RUN_BIT]);
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   rst_quiet_a: assert property (disable iff (1'b0)
      srst |=> !led_output_pin && !wdt_clear && reg_rdata == '0)
      else $error("outputs busy after reset");
   clear_pulse_a: assert property (wdt_clear |=> !wdt_clear)
      else $error("clear pulse too long");
   clear_cause_a: assert property (wdt_clear |-> since_q <= 4'h8)
      else $error("clear without a tick");
   tick_clear_a: assert property ($rose(wdt_tick_pin) && armed_q
      |-> ##[1:6] wdt_clear)
      else $error("tick not answered by clear");
   led_cause_a: assert property ($changed(led_output_pin) |-> since_q <= 4'h8)
      else $error("led moved without a tick");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data without a read");
   unmapped_a: assert property (reg_rd && reg_addr[1:0] != 2'h0
      |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   led_status_a: assert property (reg_rd && reg_addr == STATUS_OFS
      |=> reg_rdata[ST_LED_BIT] == $past(led_output_pin))
      else $error("status led bit differs");
   // Main scenarios reached
   led_c: cover property ($changed(led_output_pin));
   clear_c: cover property (wdt_clear);
   status_c: cover property (reg_rd && reg_addr == STATUS_OFS);
endmodule : cit_props

bind cit_interval_timer cit_props u_props (.clk, .srst, .wdt_tick_pin,
   .switch_input_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .led_output_pin, .wdt_clear);

//--- tb/cit_button_model.sv
// Push button and LED standing on the far side of the timer
`timescale 1ns/1ns
module cit_button_model (
   input wire logic clk,
   input wire logic press,
   input wire logic led_output_pin,
   output logic switch_input_pin,
   output int toggles
);
   logic led_q = 1'b0; // LED level one cycle back
   // Pressed button pulls low, pull-up holds it high otherwise
   assign switch_input_pin = press ? 1'b0 : 1'b1;
   int count_q = 0; // Toggles seen so far, one driver only
   // Count LED toggles seen at the pin
   assign toggles = count_q;
   always @(posedge clk) begin
      led_q <= led_output_pin;
      count_q <= count_q + int'(led_q !== led_output_pin);
   end
endmodule : cit_button_model

//--- tb/tb_cit_interval_timer.sv
// Self-checking bench for the calibrated interval timer
`timescale 1ns/1ns
module tb_cit_interval_timer import cit_pkg::*; ;
   // Short measurement gives 66 ticks a base period, plus the opening tick
   localparam int PER = 67;
   logic clk, srst, wdt_tick_pin, switch_input_pin, press;
   logic reg_wr, reg_rd, led_output_pin, wdt_clear;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int err_total, n_checks, ticks, tog;
   bit tick_en; // Tick source running
   cit_interval_timer uut (.clk, .srst, .wdt_tick_pin, .switch_input_pin,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .led_output_pin,
      .wdt_clear);
   cit_button_model u_btn (.clk, .press, .led_output_pin, .switch_input_pin,
      .toggles(tog));
   // ------------------------------------------------------------
   // Clock and slow tick, 100 clocks a tick
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always begin
      @(posedge clk);
      if (tick_en) begin
         repeat (49) @(posedge clk);
         wdt_tick_pin <= 1'b1;
         ticks <= ticks + 1;
         repeat (50) @(posedge clk);
         wdt_tick_pin <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the read edge
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Let n ticks pass and their processing settle
   task automatic wait_ticks(input int n);
      int t;
      t = ticks + n;
      while (ticks < t) @(posedge clk);
      repeat (10) @(posedge clk);
   endtask : wait_ticks
   // Wait for the next LED toggle, bounded, and note its tick
   task automatic wait_tog(output int at);
      int t0;
      t0 = tog;
      for (int i = 0; i < 30000 && tog == t0; i++) @(posedge clk);
      chk("led toggle seen", 32'(tog != t0), 32'h1);
      at = ticks;
   endtask : wait_tog
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] v;
      rd(MEAS_OFS, v);
      chk("meas preload", 32'(v[15:0]), 32'h29);
      rd(STATUS_OFS, v);
      chk("measure state", 32'(v[5:4]), 32'h1);
      chk("tick masked", 32'(v[2]), 32'h0);
      chk("counters clear", 32'({v[18:16], v[11:8]}), 32'h0);
      rd(4'h2, v);
      chk("unmapped", v, 32'h0);
      rd(CTRL_OFS, v);
      chk("run after reset", v, 32'h1);
      wr(CTRL_OFS, 32'h0);
      rd(STATUS_OFS, v);
      chk("held in init", 32'(v[5:4]), 32'h0);
      wr(CTRL_OFS, 32'h1);
      tick_en <= 1'b1;
   endtask : t_regs
   task automatic t_init();
      logic [31:0] v;
      wait_ticks(1);
      rd(STATUS_OFS, v);
      chk("idle state", 32'(v[5:4]), 32'h2);
      chk("led off, enables", 32'(v[2:0]), 32'h6);
      rd(COUNT_OFS, v);
      chk("first load", 32'(v[15:0]), 32'h0142);
   endtask : t_init
   task automatic t_period();
      int a, b;
      logic [31:0] v;
      wait_tog(a);
      chk("first expiry", 32'(a), 32'(PER));
      chk("led on", 32'(led_output_pin), 32'h1);
      wait_tog(b);
      chk("base period", 32'(b - a), 32'(PER));
      rd(COUNT_OFS, v);
      chk("reload", 32'(v[15:8]), 32'h1);
   endtask : t_period
   // Press, held through debounce or released early
   task automatic t_press(input bit hold, input logic [2:0] key);
      logic [31:0] v;
      wait_ticks(1);
      press <= 1'b1;
      repeat (20) @(posedge clk);
      rd(STATUS_OFS, v);
      chk("debounce load", 32'({v[11:8], v[1]}), 32'h12);
      press <= hold;
      // One tick later, bounce the held button: the new edge must be ignored
      wait_ticks(1);
      press <= 1'b0;
      repeat (10) @(posedge clk);
      press <= hold;
      repeat (10) @(posedge clk);
      rd(STATUS_OFS, v);
      chk("chatter ignored", 32'({v[11:8], v[1]}), 32'h10);
      wait_ticks(11);
      rd(STATUS_OFS, v);
      chk("key count", 32'({v[18:16], v[1], v[11:8]}), 32'({key, 5'h10}));
      press <= 1'b0;
   endtask : t_press
   task automatic t_two();
      int a, b;
      wait_tog(a);
      wait_tog(b);
      chk("two periods", 32'(b - a), 32'(2 * PER));
   endtask : t_two
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      wdt_tick_pin = 1'b0;
      press = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      tick_en = 1'b0;
      err_total = 0;
      n_checks = 0;
      ticks = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_init();
      t_period();
      t_press(1'b0, 3'h0);
      t_press(1'b1, 3'h1);
      t_two();
      for (int k = 2; k <= 5; k++) begin
         t_press(1'b1, 3'(k % 5));
      end
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule : tb_cit_interval_timer
